// ---- mdwsg_pkg.sv ----
// Shared constants and types for the memory decode and wait-state block.
// Assumes one 125 MHz system clock and a 16-bit processor address bus.
package mdwsg_pkg;

    // Clock and bus geometry
    localparam int CLK_PERIOD_NS = 8;
    localparam int ADDR_W = 16;
    localparam int SEG_N = 8;
    localparam int SEG_MSB = 15;
    localparam int SEG_LSB = 13;
    localparam int HALF_BIT = 15;

    // Segment positions of the two documented banks
    localparam logic [2:0] EPROM_SEG = 3'h0;
    localparam logic [2:0] SRAM_SEG = 3'h1;
    localparam int FAST_SEG_LAST = 3;

    // Access-time bands that set the wait count
    localparam int ONE_WAIT_MIN_NS = 40;
    localparam int TWO_WAIT_MIN_NS = 140;
    localparam int TWO_WAIT_MAX_NS = 240;

    // Overall access time of each slow region
    localparam int EPROM_ACCESS_NS = 220;
    localparam int DATA_UPPER_ACCESS_NS = 130;

    // Reset values
    localparam logic [7:0] SEL_RESET = 8'hff;
    localparam logic STROBE_RESET = 1'h1;
    localparam logic READY_RESET = 1'h1;
    localparam logic [1:0] WAIT_CNT_RESET = 2'h0;

    typedef logic [1:0] mdwsg_waits_t;

    // Processor pins as one bundle
    typedef struct packed {
        logic proc_clk;
        logic rnw;
        logic ps_n;
        logic ds_n;
        logic strobe_n;
        logic [ADDR_W-1:0] addr;
    } mdwsg_bus_t;

    // Idle bus: strobes and selects high, read, address zero
    localparam mdwsg_bus_t BUS_IDLE = 21'h0f0000;

    typedef enum logic [1:0] {
        WG_IDLE = 2'b00,
        WG_COUNT = 2'b01,
        WG_DONE = 2'b10
    } mdwsg_wg_state_t;

    // Wait states needed for an overall access time; 3 marks out of range
    function automatic mdwsg_waits_t waits_for_ns(input int ns);
        if (ns <= ONE_WAIT_MIN_NS) begin
            return 2'h0;
        end else if (ns < TWO_WAIT_MIN_NS) begin
            return 2'h1;
        end else if (ns < TWO_WAIT_MAX_NS) begin
            return 2'h2;
        end
        return 2'h3;
    endfunction : waits_for_ns

endpackage : mdwsg_pkg

// ---- mdwsg_wait_gen.sv ----
// Wait-state generator: counts processor clock edges for one slow access.
// Assumes its inputs are already synchronised to clk_sys_in.
`timescale 1ns/100ps
`default_nettype none
module mdwsg_wait_gen (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Access control
    input wire logic start_in,
    input wire logic active_in,
    input wire mdwsg_pkg::mdwsg_waits_t waits_in,
    input wire logic proc_clk_in,
    // Result
    output logic done_out
);

    mdwsg_pkg::mdwsg_wg_state_t state_r, state_nxt;
    mdwsg_pkg::mdwsg_waits_t cnt_r, cnt_nxt;
    logic clk_d_r, clk_d_nxt;
    logic edge_seen;

    ////////////////////////////////////////////////////////////////////////
    // Next state: count rising processor clock edges, then hold done
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        clk_d_nxt = proc_clk_in;
        edge_seen = proc_clk_in & ~clk_d_r;
        case (state_r)
            mdwsg_pkg::WG_IDLE: begin
                cnt_nxt = mdwsg_pkg::WAIT_CNT_RESET;
                if (start_in) begin
                    state_nxt = mdwsg_pkg::WG_COUNT;
                end
            end
            mdwsg_pkg::WG_COUNT: begin
                if (!active_in) begin
                    state_nxt = mdwsg_pkg::WG_IDLE;
                end else if (cnt_r == waits_in) begin
                    state_nxt = mdwsg_pkg::WG_DONE;
                end else if (edge_seen) begin
                    cnt_nxt = cnt_r + 2'h1;
                end
            end
            mdwsg_pkg::WG_DONE: begin
                if (!active_in) begin
                    state_nxt = mdwsg_pkg::WG_IDLE;
                end
            end
            default: begin
                state_nxt = mdwsg_pkg::WG_IDLE;
            end
        endcase
    end

    // Registers only
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_r <= mdwsg_pkg::WG_IDLE;
            cnt_r <= mdwsg_pkg::WAIT_CNT_RESET;
            clk_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            clk_d_r <= clk_d_nxt;
        end
    end

    assign done_out = (state_r == mdwsg_pkg::WG_DONE);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_done_needs_count: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(done_out) |-> $past(cnt_r) == waits_in)
        else $error("done raised before the wait count was reached");

    a_start_counts: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_r == mdwsg_pkg::WG_IDLE && start_in) |=> !done_out)
        else $error("done raised on the first cycle of an access");

endmodule : mdwsg_wait_gen
`default_nettype wire

// ---- mdwsg_top.sv ----
// Memory decode and wait-state glue between a processor bus and its memories.
// Assumes the processor pins are asynchronous to clk_sys_in; one clock only.
`timescale 1ns/100ps
`default_nettype none
module mdwsg_top #(
    parameter int EPROM_ACCESS_NS = mdwsg_pkg::EPROM_ACCESS_NS,
    parameter int DATA_UPPER_ACCESS_NS = mdwsg_pkg::DATA_UPPER_ACCESS_NS,
    parameter bit NO_WAIT_SYSTEM = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Processor bus pins
    input wire logic [mdwsg_pkg::ADDR_W-1:0] proc_addr_in,
    input wire logic bus_strobe_n_in,
    input wire logic data_space_select_n_in,
    input wire logic program_space_select_n_in,
    input wire logic read_not_write_in,
    input wire logic proc_clock_in,
    // Memory selects
    output logic [mdwsg_pkg::SEG_N-1:0] program_segment_select_n_out,
    output logic [mdwsg_pkg::SEG_N-1:0] data_segment_select_n_out,
    output logic memory_select_n_out,
    output logic segment1_select_n_out,
    // EPROM buffer and SRAM control
    output logic data_buffer_strobe_n_out,
    output logic sram_output_enable_n_out,
    output logic sram_write_enable_n_out,
    output logic sram_write_capture_out,
    // Ready path
    output logic zero_wait_decode_n_out,
    output logic ready_out
);

    localparam mdwsg_pkg::mdwsg_waits_t EPROM_WAITS =
        mdwsg_pkg::waits_for_ns(EPROM_ACCESS_NS);
    localparam mdwsg_pkg::mdwsg_waits_t DATA_WAITS =
        mdwsg_pkg::waits_for_ns(DATA_UPPER_ACCESS_NS);

    mdwsg_pkg::mdwsg_bus_t pins;
    mdwsg_pkg::mdwsg_bus_t s1_r, s2_r, s3_r, q_r, q_nxt;
    mdwsg_pkg::mdwsg_bus_t diff;

    logic [2:0] seg;
    logic prog_en, data_en;
    logic [mdwsg_pkg::SEG_N-1:0] prog_sel_nxt, data_sel_nxt;
    logic [mdwsg_pkg::SEG_N-1:0] prog_sel_r, data_sel_r;
    logic mem_sel_nxt, mem_sel_r;
    logic buf_nxt, buf_r;
    logic oe_nxt, oe_r, we_nxt, we_r;
    logic cap_nxt, cap_r;
    logic zw_nxt, zw_r;
    logic ready_nxt, ready_r;
    logic prog_slow, data_slow, need_wait, active, start;
    logic gen_done;
    mdwsg_pkg::mdwsg_waits_t waits_sel;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: three stages, a bit moves once stages two and three agree
    assign pins = '{
        proc_clk: proc_clock_in,
        rnw: read_not_write_in,
        ps_n: program_space_select_n_in,
        ds_n: data_space_select_n_in,
        strobe_n: bus_strobe_n_in,
        addr: proc_addr_in
    };

    always_comb begin
        diff = s2_r ^ s3_r;
        q_nxt = (s3_r & ~diff) | (q_r & diff);
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            s1_r <= mdwsg_pkg::BUS_IDLE;
            s2_r <= mdwsg_pkg::BUS_IDLE;
            s3_r <= mdwsg_pkg::BUS_IDLE;
            q_r <= mdwsg_pkg::BUS_IDLE;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Segment decoders; program side is write-blocked so a stray write
    // to the EPROMs cannot fight them on the bus
    assign seg = q_r.addr[mdwsg_pkg::SEG_MSB:mdwsg_pkg::SEG_LSB];
    assign prog_en = ~q_r.ps_n & q_r.rnw;
    assign data_en = ~q_r.ds_n & ~q_r.strobe_n;

    genvar gi;
    generate
        for (gi = 0; gi < mdwsg_pkg::SEG_N; gi++) begin : g_seg
            assign prog_sel_nxt[gi] = ~(prog_en && seg == 3'(gi));
            assign data_sel_nxt[gi] = ~(data_en && seg == 3'(gi));
        end
    endgenerate

    // EPROM select, buffer strobe and SRAM controls
    always_comb begin
        mem_sel_nxt = prog_sel_nxt[mdwsg_pkg::EPROM_SEG];
        buf_nxt = mem_sel_nxt | q_r.strobe_n;
        oe_nxt = data_sel_nxt[mdwsg_pkg::SRAM_SEG] | ~q_r.rnw;
        we_nxt = data_sel_nxt[mdwsg_pkg::SRAM_SEG] | q_r.rnw;
        // One pulse on the select's rising edge of a write
        cap_nxt = ~we_r & we_nxt;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            prog_sel_r <= mdwsg_pkg::SEL_RESET;
            data_sel_r <= mdwsg_pkg::SEL_RESET;
            mem_sel_r <= mdwsg_pkg::STROBE_RESET;
            buf_r <= mdwsg_pkg::STROBE_RESET;
            oe_r <= mdwsg_pkg::STROBE_RESET;
            we_r <= mdwsg_pkg::STROBE_RESET;
            cap_r <= 1'b0;
        end else begin
            prog_sel_r <= prog_sel_nxt;
            data_sel_r <= data_sel_nxt;
            mem_sel_r <= mem_sel_nxt;
            buf_r <= buf_nxt;
            oe_r <= oe_nxt;
            we_r <= we_nxt;
            cap_r <= cap_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready decode, kept apart from the select decode so ready settles
    // from address and space selects alone, well before the strobe
    always_comb begin
        zw_nxt = q_r.ds_n | q_r.addr[mdwsg_pkg::HALF_BIT];
        prog_slow = ~q_r.ps_n & ~q_r.addr[mdwsg_pkg::HALF_BIT];
        data_slow = ~q_r.ds_n & q_r.addr[mdwsg_pkg::HALF_BIT];
        waits_sel = prog_slow ? EPROM_WAITS : DATA_WAITS;
        need_wait = (prog_slow | data_slow) && waits_sel != 2'h0;
        active = ~q_r.ps_n | ~q_r.ds_n;
        start = need_wait & ~NO_WAIT_SYSTEM;
        // No slow memory: ready simply stays high
        ready_nxt = NO_WAIT_SYSTEM | ~need_wait | gen_done;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            zw_r <= mdwsg_pkg::STROBE_RESET;
            ready_r <= mdwsg_pkg::READY_RESET;
        end else begin
            zw_r <= zw_nxt;
            ready_r <= ready_nxt;
        end
    end

    // Counting is in processor clock edges, not system cycles
    mdwsg_wait_gen u_wait_gen (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .start_in(start),
        .active_in(active),
        .waits_in(waits_sel),
        .proc_clk_in(q_r.proc_clk),
        .done_out(gen_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign program_segment_select_n_out = prog_sel_r;
    assign data_segment_select_n_out = data_sel_r;
    assign memory_select_n_out = mem_sel_r;
    assign segment1_select_n_out = data_sel_r[mdwsg_pkg::SRAM_SEG];
    assign data_buffer_strobe_n_out = buf_r;
    assign sram_output_enable_n_out = oe_r;
    assign sram_write_enable_n_out = we_r;
    assign sram_write_capture_out = cap_r;
    assign zero_wait_decode_n_out = zw_r;
    assign ready_out = ready_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    a_buf_strobe_rise: assert property (
        $past(q_r.strobe_n) |-> data_buffer_strobe_n_out)
        else $error("buffer strobe low while bus strobe high");

    a_buf_strobe_low: assert property (
        !data_buffer_strobe_n_out |-> !$past(q_r.strobe_n) && !$past(mem_sel_nxt))
        else $error("buffer strobe low without select and strobe");

    a_zero_wait_dec: assert property (
        zero_wait_decode_n_out == ($past(q_r.ds_n) | $past(q_r.addr[15])))
        else $error("zero-wait decode wrong");

    a_data_seg_onehot: assert property (
        $onehot0(~data_segment_select_n_out))
        else $error("more than one data segment selected");

    a_sel_needs_strobe: assert property (
        (data_segment_select_n_out != 8'hff) |-> !$past(q_r.strobe_n))
        else $error("data select without bus strobe");

    a_eprom_base: assert property (
        !memory_select_n_out |-> $past(seg) == 3'h0 && !$past(q_r.ps_n))
        else $error("EPROM select outside segment 0");

    a_sram_base: assert property (
        !segment1_select_n_out |-> $past(seg) == 3'h1 && !$past(q_r.ds_n))
        else $error("SRAM select outside 2000h segment");

    a_sram_no_drive: assert property (
        !sram_output_enable_n_out |-> $past(q_r.rnw))
        else $error("SRAM output enabled during a write");

    a_sram_capture: assert property (
        $rose(sram_write_enable_n_out) |-> sram_write_capture_out ##1 !sram_write_capture_out)
        else $error("write capture pulse missing or too long");

    a_ready_low_start: assert property (
        (!NO_WAIT_SYSTEM && need_wait && !gen_done) |=> !ready_out)
        else $error("ready high during an uncounted wait");

    a_eprom_two_waits: assert property (
        (prog_slow && EPROM_ACCESS_NS > 140 && EPROM_ACCESS_NS < 240) |-> waits_sel == 2'h2)
        else $error("slow EPROM not given two waits");

    a_data_one_wait: assert property (
        (data_slow && !prog_slow && DATA_UPPER_ACCESS_NS > mdwsg_pkg::ONE_WAIT_MIN_NS
            && DATA_UPPER_ACCESS_NS < mdwsg_pkg::TWO_WAIT_MIN_NS) |-> waits_sel == 2'h1)
        else $error("upper data region not given one wait");

    // Check helper: synced processor clock rises seen while ready is held low
    logic pclk_d_r, pclk_d_nxt;
    mdwsg_pkg::mdwsg_waits_t low_edges_r, low_edges_nxt;

    // Saturates so a stuck ready cannot wrap back to a plausible count
    always_comb begin
        pclk_d_nxt = q_r.proc_clk;
        low_edges_nxt = low_edges_r;
        if (ready_out) begin
            low_edges_nxt = 2'h0;
        end else if (q_r.proc_clk && !pclk_d_r && low_edges_r != 2'h3) begin
            low_edges_nxt = low_edges_r + 2'h1;
        end
    end

    // Helper registers only
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pclk_d_r <= 1'b0;
            low_edges_r <= 2'h0;
        end else begin
            pclk_d_r <= pclk_d_nxt;
            low_edges_r <= low_edges_nxt;
        end
    end

    a_ready_wait_count: assert property (
        $rose(ready_out) && gen_done |-> low_edges_r == $past(waits_sel))
        else $error("ready rose after the wrong number of processor clock edges");

    a_no_wait_ready: assert property (
        NO_WAIT_SYSTEM |-> ready_out)
        else $error("ready dropped in a system without slow memory");

    a_prog_read_only: assert property (
        (program_segment_select_n_out != 8'hff) |-> $past(q_r.rnw))
        else $error("program select asserted during a write");

    a_sram_write_dir: assert property (
        !sram_write_enable_n_out |-> !$past(q_r.rnw) && !segment1_select_n_out)
        else $error("SRAM write enable outside a segment 1 write");

    a_fast_data_ready: assert property (
        (!q_r.ds_n && !q_r.addr[mdwsg_pkg::HALF_BIT] && q_r.ps_n) |=> ready_out)
        else $error("ready dropped for a fast data segment");

    c_eprom_read: cover property (!data_buffer_strobe_n_out ##[1:400] ready_out);
    c_sram_write: cover property (sram_write_capture_out);
    c_data_wait: cover property (data_slow ##[1:400] gen_done);
    c_zero_wait: cover property (!zero_wait_decode_n_out && !segment1_select_n_out);
    c_one_wait: cover property ($rose(ready_out) && gen_done && waits_sel == 2'h1);

endmodule : mdwsg_top
`default_nettype wire

// ---- mdwsg_proc_model.sv ----
// Behavioural processor bus model driving the glue's pin bundle.
// Assumes the bench calls put() and strobe(); pins change on falling clk.
`timescale 1ns/100ps
`default_nettype none
module mdwsg_proc_model #(
    parameter int PCLK_HALF = 8
) (
    // System clock
    input wire logic clk_sys_in,
    // Processor pins
    output var mdwsg_pkg::mdwsg_bus_t bus_out
);
    int half_cnt;

    // Idle pins from time zero
    initial begin
        bus_out = mdwsg_pkg::BUS_IDLE;
        half_cnt = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Processor clock runs free; slow enough that sync lag stays inside a half
    always @(negedge clk_sys_in) begin
        half_cnt = half_cnt + 1;
        if (half_cnt == PCLK_HALF) begin
            half_cnt = 0;
            bus_out.proc_clk = ~bus_out.proc_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address, space and direction change together
    task automatic put(input logic [15:0] addr, input logic ps_n, input logic ds_n,
                       input logic rnw);
        @(negedge clk_sys_in);
        bus_out.addr = addr;
        bus_out.ps_n = ps_n;
        bus_out.ds_n = ds_n;
        bus_out.rnw = rnw;
    endtask : put

    // Strobe low opens a transfer, high ends it
    task automatic strobe(input logic level);
        @(negedge clk_sys_in);
        bus_out.strobe_n = level;
    endtask : strobe

endmodule : mdwsg_proc_model
`default_nettype wire

// ---- tb_memory_decode_wait_state_gen.sv ----
// Self-checking bench for the memory decode and wait-state glue.
// Assumes the processor model drives all bus pins; one system clock.
`timescale 1ns/100ps
`default_nettype none
module tb_memory_decode_wait_state_gen;
    logic clk_sys_in;
    logic rst_in;
    mdwsg_pkg::mdwsg_bus_t bus;
    logic [7:0] prog_sel_n;
    logic [7:0] data_sel_n;
    logic mem_sel_n, seg1_n, dbs_n, oe_n, we_n, cap, zw_n, ready;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int pedges = 0;

    mdwsg_proc_model u_mdwsg_proc_model (.clk_sys_in(clk_sys_in), .bus_out(bus));

    // Plain pin nets from the model's bundle, shared by both glue copies
    wire logic [15:0] pin_addr = bus.addr;
    wire logic pin_strobe_n = bus.strobe_n;
    wire logic pin_ds_n = bus.ds_n;
    wire logic pin_ps_n = bus.ps_n;
    wire logic pin_rnw = bus.rnw;
    wire logic pin_pclk = bus.proc_clk;
    logic ready_nw;

    // Copy built for a system without slow memory: ready must never drop
    if (1) begin : g_no_wait
        mdwsg_top #(.NO_WAIT_SYSTEM(1'b1)) u_mdwsg_top (
            .clk_sys_in(clk_sys_in), .rst_in(rst_in), .proc_addr_in(pin_addr),
            .bus_strobe_n_in(pin_strobe_n), .data_space_select_n_in(pin_ds_n),
            .program_space_select_n_in(pin_ps_n), .read_not_write_in(pin_rnw),
            .proc_clock_in(pin_pclk), .program_segment_select_n_out(),
            .data_segment_select_n_out(), .memory_select_n_out(),
            .segment1_select_n_out(), .data_buffer_strobe_n_out(),
            .sram_output_enable_n_out(), .sram_write_enable_n_out(),
            .sram_write_capture_out(), .zero_wait_decode_n_out(),
            .ready_out(ready_nw)
        );
    end

    mdwsg_top u_mdwsg_top (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .proc_addr_in(pin_addr),
        .bus_strobe_n_in(pin_strobe_n), .data_space_select_n_in(pin_ds_n),
        .program_space_select_n_in(pin_ps_n), .read_not_write_in(pin_rnw),
        .proc_clock_in(pin_pclk), .program_segment_select_n_out(prog_sel_n),
        .data_segment_select_n_out(data_sel_n), .memory_select_n_out(mem_sel_n),
        .segment1_select_n_out(seg1_n), .data_buffer_strobe_n_out(dbs_n),
        .sram_output_enable_n_out(oe_n), .sram_write_enable_n_out(we_n),
        .sram_write_capture_out(cap), .zero_wait_decode_n_out(zw_n),
        .ready_out(ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    // Processor clock edges seen at the pins, for wait counting
    always @(posedge bus.proc_clk) pedges++;

    // Hang guard; the full run needs well under 3000 cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            $display("FAIL at %0t ns: timeout got %h expected %h", $time, cycles, 0);
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : wc

    // Bounded wait for ready, then count processor edges since access start
    task automatic wait_ready(input int e0, input int waits);
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 200) begin
            wc(1);
            k++;
        end
        chk(16'(pedges - e0), 16'(waits));
    endtask : wait_ready

    task automatic go_idle();
        u_mdwsg_proc_model.put(16'hffff, 1'b1, 1'b1, 1'b1);
        wc(8);
    endtask : go_idle

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        chk(prog_sel_n, 8'hff);
        chk(data_sel_n, 8'hff);
        chk({mem_sel_n, seg1_n, dbs_n, oe_n, we_n, zw_n}, 16'h003f);
        chk(ready, 1'b1);
        chk(ready_nw, 1'b1);
        chk(cap, 1'b0);
        $display("test reset done");
    endtask : test_reset

    // Slow program read at 0000h through the buffer strobe
    task automatic test_eprom_read();
        int e0;
        @(negedge bus.proc_clk);
        e0 = pedges;
        u_mdwsg_proc_model.put(16'h0000, 1'b0, 1'b1, 1'b1);
        wc(8);
        chk(mem_sel_n, 1'b0);
        chk(prog_sel_n, 8'hfe);
        chk(ready, 1'b0);
        chk(ready_nw, 1'b1);
        chk(dbs_n, 1'b1);
        u_mdwsg_proc_model.strobe(1'b0);
        wc(8);
        chk(dbs_n, 1'b0);
        wait_ready(e0, 2);
        u_mdwsg_proc_model.strobe(1'b1);
        wc(8);
        chk(dbs_n, 1'b1);
        chk(mem_sel_n, 1'b0);
        go_idle();
        chk(mem_sel_n, 1'b1);
        chk(ready, 1'b1);
        $display("test eprom read done");
    endtask : test_eprom_read

    // Read every data segment: strobe gating, zero-wait decode, wait count
    task automatic test_data_segments();
        int e0;
        logic [2:0] seg;
        for (int s = 0; s < 8; s++) begin
            seg = 3'(s);
            @(negedge bus.proc_clk);
            e0 = pedges;
            u_mdwsg_proc_model.put({seg, 13'h0000}, 1'b1, 1'b0, 1'b1);
            wc(8);
            chk(data_sel_n, 8'hff);
            chk(zw_n, seg[2]);
            chk(ready, !seg[2]);
            chk(ready_nw, 1'b1);
            u_mdwsg_proc_model.strobe(1'b0);
            if (seg[2]) wait_ready(e0, 1);
            wc(8);
            chk(data_sel_n, {8'h00, ~(8'h01 << seg)});
            chk(seg1_n, seg != 3'h1);
            chk(oe_n, seg != 3'h1);
            u_mdwsg_proc_model.strobe(1'b1);
            wc(8);
            chk(data_sel_n, 8'hff);
            go_idle();
        end
        $display("test data segments done");
    endtask : test_data_segments

    // SRAM write at 2000h: outputs off, one capture as the select rises
    task automatic test_sram_write();
        int n;
        u_mdwsg_proc_model.put(16'h2000, 1'b1, 1'b0, 1'b0);
        wc(8);
        chk(we_n, 1'b1);
        u_mdwsg_proc_model.strobe(1'b0);
        wc(8);
        chk({seg1_n, we_n, oe_n, ready}, 16'h0003);
        u_mdwsg_proc_model.strobe(1'b1);
        n = 0;
        repeat (12) begin
            wc(1);
            if (cap === 1'b1) begin
                n++;
                chk(we_n, 1'b1);
            end
        end
        chk(16'(n), 16'h0001);
        go_idle();
        $display("test sram write done");
    endtask : test_sram_write

    // Program-space write must select nothing and keep the buffers shut
    task automatic test_prog_write();
        u_mdwsg_proc_model.put(16'h0000, 1'b0, 1'b1, 1'b0);
        u_mdwsg_proc_model.strobe(1'b0);
        wc(8);
        chk(prog_sel_n, 8'hff);
        chk({mem_sel_n, dbs_n}, 16'h0003);
        u_mdwsg_proc_model.strobe(1'b1);
        go_idle();
        $display("test program write done");
    endtask : test_prog_write

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin
        rst_in = 1'b1;
        wc(4);
        rst_in = 1'b0;
        test_reset();
        wc(8);
        test_eprom_read();
        test_data_segments();
        test_sram_write();
        test_prog_write();
        print_verdict();
    end

endmodule : tb_memory_decode_wait_state_gen
`default_nettype wire
